/* File: common/pio_pkg.sv */
// Constants, register map and rule summary of the parallel I/O position command block.
// Operation
// - Pattern 0: binary select of 64 positions, zone and position zone outputs.
// - Pattern 1: binary select of 64 positions, input stores present position into table.
// - Pattern 2: binary select of 256 positions with one position zone output.
// - Pattern 3: binary select of 512 positions, no zone output at all.
// - Pattern 4: seven individual position inputs, zone and position zone outputs.
// - Pattern 5: three individual inputs, completion shown as limit-switch style outputs.
// - General zone output only after homing, bounds from one of two pairs.
// - Position zone valid only for the commanded position, off once another selected.
// - A setting makes the position zone output behave as the general zone.
// - Mode 2 pattern 1 runs input-commanded jog at configurable speed, default 100.
// - Jog speed never exceeds 250 mm/s whatever is configured.
// - Start treatment applies only in mode 1 pattern 1 and mode 2 patterns 4, 5.
// - Level treatment: move while start held; release decelerates and ends operation.
// - Edge treatment: a rising start transition begins the move.
// - Edge treatment: move continues to target even if start drops.
// - Pattern select accepts only 0 to 5 and defaults to 0.
`default_nettype none

package pio_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned POS_W  = 16;
	localparam int unsigned SEL_W  = 9;
	localparam int unsigned ST_W   = 7;

	// Register indices on the plain register port.
	localparam logic [ADDR_W-1:0] REG_CFG    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_JOG    = 4'h1;
	localparam logic [ADDR_W-1:0] REG_JOG2   = 4'h2;
	localparam logic [ADDR_W-1:0] REG_Z1_LO  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_Z1_HI  = 4'h4;
	localparam logic [ADDR_W-1:0] REG_Z2_LO  = 4'h5;
	localparam logic [ADDR_W-1:0] REG_Z2_HI  = 4'h6;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;

	// Configuration register fields.
	localparam int unsigned CFG_PAT_LSB  = 0;
	localparam int unsigned CFG_PAT_W    = 3;
	localparam int unsigned CFG_MODE2    = 3;
	localparam int unsigned CFG_EDGE     = 4;
	localparam int unsigned CFG_ZSEL     = 5;
	localparam int unsigned CFG_PZ_AS_Z  = 6;

	localparam logic [CFG_PAT_W-1:0] PAT_STD     = 3'h0;
	localparam logic [CFG_PAT_W-1:0] PAT_TEACH   = 3'h1;
	localparam logic [CFG_PAT_W-1:0] PAT_256     = 3'h2;
	localparam logic [CFG_PAT_W-1:0] PAT_512     = 3'h3;
	localparam logic [CFG_PAT_W-1:0] PAT_SOL7    = 3'h4;
	localparam logic [CFG_PAT_W-1:0] PAT_SOL3    = 3'h5;
	localparam logic [CFG_PAT_W-1:0] PAT_MAX     = 3'h5;

	localparam logic [DATA_W-1:0] JOG_RST  = 16'h0064;
	localparam logic [DATA_W-1:0] JOG_MAX  = 16'h00FA;
	localparam logic [DATA_W-1:0] ZONE_RST = 16'h0000;

	localparam logic [SEL_W-1:0] MASK_64  = 9'h03F;
	localparam logic [SEL_W-1:0] MASK_256 = 9'h0FF;
	localparam logic [SEL_W-1:0] MASK_512 = 9'h1FF;

	localparam int unsigned N_SOL7 = 7;
	localparam int unsigned N_SOL3 = 3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MOVE,
		ST_STOP,
		ST_HOLD
	} pio_state_t;

endpackage : pio_pkg

`default_nettype wire

/* File: rtl/pio_cmd.sv */
// Parallel I/O position command front end: pattern decode, start handling, zones, jog.
//
// Strobed register access and the register offsets are this design's own decisions.
`default_nettype none

module pio_cmd (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic [pio_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [pio_pkg::DATA_W-1:0]  reg_wdata_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	output logic      [pio_pkg::DATA_W-1:0]  reg_rdata_o,
	input  wire logic [pio_pkg::ST_W-1:0]    start_position_input_i,
	input  wire logic [pio_pkg::SEL_W-1:0]   pos_sel_i,
	input  wire logic                        teach_i,
	input  wire logic                        jog_fwd_i,
	input  wire logic                        jog_rev_i,
	input  wire logic                        home_done_i,
	input  wire logic                        move_done_i,
	input  wire logic [pio_pkg::POS_W-1:0]   cur_pos_i,
	input  wire logic [pio_pkg::POS_W-1:0]   pzone_lo_i,
	input  wire logic [pio_pkg::POS_W-1:0]   pzone_hi_i,
	output logic                             move_req_o,
	output logic                             stop_req_o,
	output logic      [pio_pkg::SEL_W-1:0]   target_pos_o,
	output logic                             teach_wr_o,
	output logic      [pio_pkg::SEL_W-1:0]   teach_addr_o,
	output logic      [pio_pkg::POS_W-1:0]   teach_data_o,
	output logic                             jog_fwd_o,
	output logic                             jog_rev_o,
	output logic      [pio_pkg::DATA_W-1:0]  jog_speed_o,
	output logic                             zone_o,
	output logic                             pzone_o,
	output logic      [pio_pkg::N_SOL3-1:0]  limit_switch_style_complete_o
);
	import pio_pkg::*;

	localparam int unsigned PIN_W = ST_W + SEL_W + 3;

	// Synchronised pins.
	logic [PIN_W-1:0] pin_lvl;
	logic [PIN_W-1:0] pin_rise;
	logic [ST_W-1:0]  st_lvl;
	logic [ST_W-1:0]  st_rise;
	logic [SEL_W-1:0] sel_lvl;
	logic             teach_rise;
	logic             jf_lvl;
	logic             jr_lvl;

	pio_sync_edge #(
		.W      (PIN_W)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.d_i    ({jog_rev_i, jog_fwd_i, teach_i, pos_sel_i, start_position_input_i}),
		.lvl_o  (pin_lvl),
		.rise_o (pin_rise)
	);

	always_comb begin
		st_lvl     = pin_lvl[ST_W-1:0];
		st_rise    = pin_rise[ST_W-1:0];
		sel_lvl    = pin_lvl[ST_W +: SEL_W];
		teach_rise = pin_rise[ST_W+SEL_W];
		jf_lvl     = pin_lvl[ST_W+SEL_W+1];
		jr_lvl     = pin_lvl[ST_W+SEL_W+2];
	end

	// Register file.
	logic [CFG_PAT_W-1:0] pat_q, pat_d;
	logic                 mode2_q, mode2_d;
	logic                 edge_q, edge_d;
	logic                 zsel_q, zsel_d;
	logic                 pzz_q, pzz_d;
	logic [DATA_W-1:0]    jog_q, jog_d;
	logic [DATA_W-1:0]    jog2_q, jog2_d;
	logic [DATA_W-1:0]    z1lo_q, z1lo_d, z1hi_q, z1hi_d;
	logic [DATA_W-1:0]    z2lo_q, z2lo_d, z2hi_q, z2hi_d;
	logic [DATA_W-1:0]    rdata_q, rdata_d;
	pio_state_t           state_q, state_d;

	always_comb begin
		pat_d   = pat_q;
		mode2_d = mode2_q;
		edge_d  = edge_q;
		zsel_d  = zsel_q;
		pzz_d   = pzz_q;
		jog_d   = jog_q;
		jog2_d  = jog2_q;
		z1lo_d  = z1lo_q;
		z1hi_d  = z1hi_q;
		z2lo_d  = z2lo_q;
		z2hi_d  = z2hi_q;
		rdata_d = '0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CFG: begin
					if (reg_wdata_i[CFG_PAT_LSB +: CFG_PAT_W] <= PAT_MAX) begin
						pat_d = reg_wdata_i[CFG_PAT_LSB +: CFG_PAT_W];
					end
					mode2_d = reg_wdata_i[CFG_MODE2];
					edge_d  = reg_wdata_i[CFG_EDGE];
					zsel_d  = reg_wdata_i[CFG_ZSEL];
					pzz_d   = reg_wdata_i[CFG_PZ_AS_Z];
				end
				REG_JOG:   jog_d  = reg_wdata_i;
				REG_JOG2:  jog2_d = reg_wdata_i;
				REG_Z1_LO: z1lo_d = reg_wdata_i;
				REG_Z1_HI: z1hi_d = reg_wdata_i;
				REG_Z2_LO: z2lo_d = reg_wdata_i;
				REG_Z2_HI: z2hi_d = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CFG: begin
					rdata_d[CFG_PAT_LSB +: CFG_PAT_W] = pat_q;
					rdata_d[CFG_MODE2]   = mode2_q;
					rdata_d[CFG_EDGE]    = edge_q;
					rdata_d[CFG_ZSEL]    = zsel_q;
					rdata_d[CFG_PZ_AS_Z] = pzz_q;
				end
				REG_JOG:    rdata_d = jog_q;
				REG_JOG2:   rdata_d = jog2_q;
				REG_Z1_LO:  rdata_d = z1lo_q;
				REG_Z1_HI:  rdata_d = z1hi_q;
				REG_Z2_LO:  rdata_d = z2lo_q;
				REG_Z2_HI:  rdata_d = z2hi_q;
				REG_STATUS: rdata_d = {9'h000, limit_switch_style_complete_o,
					pzone_o, zone_o, 2'(state_q)};
				default:    rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pat_q   <= PAT_STD;
			mode2_q <= 1'b1;
			edge_q  <= 1'b0;
			zsel_q  <= 1'b0;
			pzz_q   <= 1'b0;
			jog_q   <= JOG_RST;
			jog2_q  <= JOG_RST;
			z1lo_q  <= ZONE_RST;
			z1hi_q  <= ZONE_RST;
			z2lo_q  <= ZONE_RST;
			z2hi_q  <= ZONE_RST;
			rdata_q <= '0;
		end else begin
			pat_q   <= pat_d;
			mode2_q <= mode2_d;
			edge_q  <= edge_d;
			zsel_q  <= zsel_d;
			pzz_q   <= pzz_d;
			jog_q   <= jog_d;
			jog2_q  <= jog2_d;
			z1lo_q  <= z1lo_d;
			z1hi_q  <= z1hi_d;
			z2lo_q  <= z2lo_d;
			z2hi_q  <= z2hi_d;
			rdata_q <= rdata_d;
		end
	end

	// Pattern decode: binary width, individual inputs, start treatment.
	logic             indiv;
	logic             use_edge;
	logic [ST_W-1:0]  st_mask;
	logic [SEL_W-1:0] bin_sel;
	logic [ST_W-1:0]  go_vec;
	logic             go_any;
	logic [SEL_W-1:0] go_idx;

	always_comb begin
		indiv   = 1'b0;
		st_mask = '0;
		bin_sel = sel_lvl & MASK_64;
		if (!mode2_q && pat_q == PAT_TEACH) begin
			indiv   = 1'b1;
			st_mask = ST_W'((1 << N_SOL3) - 1);
		end else if (mode2_q) begin
			case (pat_q)
				PAT_256:  bin_sel = sel_lvl & MASK_256;
				PAT_512:  bin_sel = sel_lvl & MASK_512;
				PAT_SOL7: begin
					indiv   = 1'b1;
					st_mask = ST_W'((1 << N_SOL7) - 1);
				end
				PAT_SOL3: begin
					indiv   = 1'b1;
					st_mask = ST_W'((1 << N_SOL3) - 1);
				end
				default: ;
			endcase
		end
		// Treatment setting counts only for individual-input patterns; binary starts are edges.
		use_edge = indiv ? edge_q : 1'b1;
		if (indiv) begin
			go_vec = (use_edge ? st_rise : st_lvl) & st_mask;
		end else begin
			go_vec = {{(ST_W-1){1'b0}}, st_rise[0]};
		end
		go_any = |go_vec;
		go_idx = '0;
		for (int i = ST_W - 1; i >= 0; i--) begin
			if (go_vec[i]) begin
				go_idx = SEL_W'(i);
			end
		end
		if (!indiv) begin
			go_idx = bin_sel;
		end
	end

	// Move sequencing, teaching and completion indication.
	logic [SEL_W-1:0]  tgt_q, tgt_d;
	logic              mreq_q, mreq_d;
	logic              sreq_q, sreq_d;
	logic              twr_q, twr_d;
	logic [SEL_W-1:0]  taddr_q, taddr_d;
	logic [POS_W-1:0]  tdata_q, tdata_d;
	logic [N_SOL3-1:0] ls_q, ls_d;
	logic              held;

	always_comb begin
		state_d = state_q;
		tgt_d   = tgt_q;
		mreq_d  = 1'b0;
		sreq_d  = 1'b0;
		twr_d   = 1'b0;
		taddr_d = taddr_q;
		tdata_d = tdata_q;
		ls_d    = ls_q;
		held    = st_lvl[tgt_q[2:0]];
		case (state_q)
			ST_IDLE: begin
				if (go_any) begin
					state_d = ST_MOVE;
					tgt_d   = go_idx;
					mreq_d  = 1'b1;
					ls_d    = '0;
				end else if (mode2_q && pat_q == PAT_TEACH && teach_rise) begin
					twr_d   = 1'b1;
					taddr_d = bin_sel;
					tdata_d = cur_pos_i;
				end
			end
			ST_MOVE: begin
				if (indiv && !use_edge && !held) begin
					state_d = ST_STOP;
					sreq_d  = 1'b1;
				end else if (move_done_i) begin
					state_d = (indiv && !use_edge) ? ST_HOLD : ST_IDLE;
					if (mode2_q && pat_q == PAT_SOL3) begin
						ls_d = N_SOL3'(1 << tgt_q[1:0]);
					end
				end
			end
			ST_STOP: begin
				if (move_done_i) begin
					state_d = ST_IDLE;
				end
			end
			ST_HOLD: begin
				// A held level start must be released before it can launch again.
				if (!held) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			tgt_q   <= '0;
			mreq_q  <= 1'b0;
			sreq_q  <= 1'b0;
			twr_q   <= 1'b0;
			taddr_q <= '0;
			tdata_q <= '0;
			ls_q    <= '0;
		end else begin
			state_q <= state_d;
			tgt_q   <= tgt_d;
			mreq_q  <= mreq_d;
			sreq_q  <= sreq_d;
			twr_q   <= twr_d;
			taddr_q <= taddr_d;
			tdata_q <= tdata_d;
			ls_q    <= ls_d;
		end
	end

	// Zones and jog.
	logic              zone_d, pzone_d, zone_q, pzone_q;
	logic              in_zone, in_pzone, has_zone, has_pzone;
	logic              jf_d, jr_d, jf_q, jr_q;
	logic [DATA_W-1:0] jspd_d, jspd_q;

	always_comb begin
		in_zone   = zsel_q ? (cur_pos_i >= z2lo_q && cur_pos_i <= z2hi_q)
			: (cur_pos_i >= z1lo_q && cur_pos_i <= z1hi_q);
		in_pzone  = cur_pos_i >= pzone_lo_i && cur_pos_i <= pzone_hi_i;
		has_zone  = mode2_q && (pat_q == PAT_STD || pat_q == PAT_SOL7 || pat_q == PAT_SOL3);
		has_pzone = mode2_q && pat_q != PAT_512;
		zone_d    = has_zone && home_done_i && in_zone;
		if (pzz_q) begin
			pzone_d = has_pzone && home_done_i && in_zone;
		end else begin
			pzone_d = has_pzone && home_done_i && state_q != ST_IDLE
				&& tgt_q == go_idx && in_pzone;
		end
		jf_d   = mode2_q && pat_q == PAT_TEACH && jf_lvl && !jr_lvl;
		jr_d   = mode2_q && pat_q == PAT_TEACH && jr_lvl && !jf_lvl;
		jspd_d = (jog_q > JOG_MAX) ? JOG_MAX : jog_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			zone_q  <= 1'b0;
			pzone_q <= 1'b0;
			jf_q    <= 1'b0;
			jr_q    <= 1'b0;
			jspd_q  <= JOG_RST;
		end else begin
			zone_q  <= zone_d;
			pzone_q <= pzone_d;
			jf_q    <= jf_d;
			jr_q    <= jr_d;
			jspd_q  <= jspd_d;
		end
	end

	always_comb begin
		reg_rdata_o  = rdata_q;
		move_req_o   = mreq_q;
		stop_req_o   = sreq_q;
		target_pos_o = tgt_q;
		teach_wr_o   = twr_q;
		teach_addr_o = taddr_q;
		teach_data_o = tdata_q;
		jog_fwd_o    = jf_q;
		jog_rev_o    = jr_q;
		jog_speed_o  = jspd_q;
		zone_o       = zone_q;
		pzone_o      = pzone_q;
		limit_switch_style_complete_o = ls_q;
	end

	chk_pattern_range: assert property (@(posedge clk_i) disable iff (rst_i)
		pat_q <= PAT_MAX) else $error("pattern select outside 0 to 5");
	chk_jog_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
		jog_speed_o == (($past(jog_q) > JOG_MAX) ? JOG_MAX : $past(jog_q)))
		else $error("jog speed not clamped or not following setting");
	chk_edge_launch: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == ST_IDLE && indiv && use_edge && |(st_rise & st_mask) |=> move_req_o)
		else $error("rising start in edge mode did not launch");
	chk_level_release: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == ST_MOVE && indiv && !use_edge && !held |=> stop_req_o ##1 !stop_req_o)
		else $error("level start release did not stop the move");
	chk_edge_no_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == ST_MOVE && use_edge |=> !stop_req_o)
		else $error("edge move stopped before target");
	chk_zone_home: assert property (@(posedge clk_i) disable iff (rst_i)
		zone_o |-> $past(home_done_i) && $past(has_zone))
		else $error("zone output without homing done");
	chk_p512_nozone: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode2_q && pat_q == PAT_512) [*2] |-> !zone_o && !pzone_o)
		else $error("zone output active in 512 point pattern");
	chk_pzone_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
		!pzz_q && $past(!pzz_q) && pzone_o |-> $past(tgt_q == go_idx))
		else $error("position zone active for a non-commanded position");
	chk_ls_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0(limit_switch_style_complete_o))
		else $error("more than one completion indication");

	cov_level_stop: cover property (@(posedge clk_i) disable iff (rst_i) stop_req_o);
	cov_teach_write: cover property (@(posedge clk_i) disable iff (rst_i) teach_wr_o);
	cov_move_zone: cover property (@(posedge clk_i) disable iff (rst_i)
		move_req_o ##[1:200] pzone_o);

endmodule : pio_cmd

`default_nettype wire

/* File: rtl/pio_sync_edge.sv */
// Two-stage input synchroniser with registered previous sample for rise detection.
`default_nettype none

module pio_sync_edge #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] lvl_o,
	output logic      [W-1:0] rise_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	always_comb begin
		lvl_o  = sync_q;
		rise_o = sync_q & ~prev_q;
	end

	chk_rise_from_samples: assert property (@(posedge clk_i) disable iff (rst_i)
		rise_o[0] |-> sync_q[0] && !$past(sync_q[0]))
		else $error("rise flagged without a low to high sample pair");

endmodule : pio_sync_edge

`default_nettype wire

/* File: test/pio_cmd_tb_top.sv */
// Self-checking testbench of the parallel I/O position command block.
`default_nettype none

module pio_cmd_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pio_pkg::*;

	logic              clk, rst, wr_s, rd_s, home_done, move_done;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, jog_spd;
	logic [POS_W-1:0]  cur_pos, pz_lo, pz_hi, t_data;
	logic [ST_W-1:0]   st;
	logic [SEL_W-1:0]  sel, target, t_addr;
	logic              teach, jf, jr, mv, stp, t_wr, jfo, jro, zone, pzone;
	logic [2:0]        ls;
	int                n_errors = 0;
	int                num_checks = 0;

	pio_host_model host (.clk_i(clk), .start_o(st), .sel_o(sel), .teach_o(teach),
		.jog_fwd_o(jf), .jog_rev_o(jr));

	pio_cmd dut (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .start_position_input_i(st),
		.pos_sel_i(sel), .teach_i(teach), .jog_fwd_i(jf), .jog_rev_i(jr),
		.home_done_i(home_done), .move_done_i(move_done), .cur_pos_i(cur_pos),
		.pzone_lo_i(pz_lo), .pzone_hi_i(pz_hi), .move_req_o(mv), .stop_req_o(stp),
		.target_pos_o(target), .teach_wr_o(t_wr), .teach_addr_o(t_addr),
		.teach_data_o(t_data), .jog_fwd_o(jfo), .jog_rev_o(jro), .jog_speed_o(jog_spd),
		.zone_o(zone), .pzone_o(pzone), .limit_switch_style_complete_o(ls));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		check(what, exp, rdata);
	endtask

	// Watches a window long enough for the pin synchroniser and the launch register.
	task automatic wait_move(input logic [SEL_W-1:0] exp);
		logic seen;
		seen = 1'b0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (mv === 1'b1) seen = 1'b1;
		end
		check("move_req", 16'h0001, {15'h0000, seen});
		check("target", {7'h00, exp}, {7'h00, target});
	endtask

	task automatic expect_stop(input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (10) begin
			@(posedge clk);
			#1;
			if (stp === 1'b1) seen = 1'b1;
		end
		check("stop_req", {15'h0000, exp}, {15'h0000, seen});
	endtask

	task automatic finish_move();
		@(posedge clk);
		move_done <= 1'b1;
		@(posedge clk);
		move_done <= 1'b0;
		cyc(2);
	endtask

	task automatic t_regs();
		check("jog_speed", 16'h0064, jog_spd);
		rd_chk("cfg", REG_CFG, 16'h0008);
		wr(REG_CFG, 16'h000E);
		rd_chk("cfg_refused", REG_CFG, 16'h0008);
		rd_chk("unmapped", 4'hF, 16'h0000);
		rd_chk("jog2", REG_JOG2, 16'h0064);
		wr(REG_JOG, 16'h012C);
		cyc(2);
		check("jog_clamp", 16'h00FA, jog_spd);
		wr(REG_JOG, 16'h00C8);
		cyc(2);
		check("jog_pass", 16'h00C8, jog_spd);
		$display("test regs done");
	endtask

	task automatic t_jog_teach();
		wr(REG_CFG, 16'h0009);
		host.drive(9'h000, 1'b0, 1'b1, 1'b0);
		cyc(5);
		check("jog_fwd", 16'h0001, {15'h0000, jfo});
		host.drive(9'h000, 1'b0, 1'b1, 1'b1);
		cyc(5);
		check("jog_both", 16'h0000, {14'h0000, jfo, jro});
		host.drive(9'h000, 1'b0, 1'b0, 1'b1);
		cyc(5);
		check("jog_rev", 16'h0001, {15'h0000, jro});
		cur_pos <= 16'h1234;
		host.drive(9'h005, 1'b0, 1'b0, 1'b0);
		cyc(4);
		host.drive(9'h005, 1'b1, 1'b0, 1'b0);
		repeat (8) begin
			@(posedge clk);
			#1;
			if (t_wr === 1'b1) break;
		end
		check("teach_wr", 16'h0001, {15'h0000, t_wr});
		check("teach_addr", 16'h0005, {7'h00, t_addr});
		check("teach_data", 16'h1234, t_data);
		host.drive(9'h000, 1'b0, 1'b0, 1'b0);
		$display("test jog and teach done");
	endtask

	task automatic t_binary();
		logic [2:0] pat [3] = '{3'h0, 3'h2, 3'h3};
		logic [8:0] msk [3] = '{MASK_64, MASK_256, MASK_512};
		pz_lo <= 16'h0000;
		pz_hi <= 16'hFFFF;
		// The position zone is only judged once homing has finished.
		home_done <= 1'b1;
		host.drive(9'h1FF, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			wr(REG_CFG, {13'h0001, pat[i]});
			host.press(0);
			wait_move(msk[i]);
			if (i == 2) check("pzone_p3", 16'h0000, {15'h0000, pzone});
			if (i == 1) check("pzone_p2", 16'h0001, {15'h0000, pzone});
			host.release_all();
			expect_stop(1'b0);
			finish_move();
		end
		host.drive(9'h003, 1'b0, 1'b0, 1'b0);
		wr(REG_CFG, 16'h0008);
		host.press(0);
		wait_move(9'h003);
		check("pzone_sel", 16'h0001, {15'h0000, pzone});
		host.drive(9'h004, 1'b0, 1'b0, 1'b0);
		cyc(5);
		check("pzone_other", 16'h0000, {15'h0000, pzone});
		host.release_all();
		finish_move();
		$display("test binary done");
	endtask

	task automatic t_zone();
		wr(REG_Z1_LO, 16'h000A);
		wr(REG_Z1_HI, 16'h0014);
		wr(REG_Z2_LO, 16'h0064);
		wr(REG_Z2_HI, 16'h00C8);
		cur_pos <= 16'h000F;
		home_done <= 1'b0;
		cyc(3);
		check("zone_unhomed", 16'h0000, {15'h0000, zone});
		home_done <= 1'b1;
		cyc(3);
		check("zone_pair1", 16'h0001, {15'h0000, zone});
		wr(REG_CFG, 16'h0028);
		cyc(3);
		check("zone_pair2", 16'h0000, {15'h0000, zone});
		wr(REG_CFG, 16'h0048);
		cyc(3);
		check("pzone_as_zone", 16'h0001, {15'h0000, pzone});
		$display("test zone done");
	endtask

	task automatic t_starts();
		wr(REG_CFG, 16'h001C);
		host.press(6);
		wait_move(9'h006);
		host.release_all();
		expect_stop(1'b0);
		finish_move();
		wr(REG_CFG, 16'h000C);
		host.press(2);
		wait_move(9'h002);
		host.release_all();
		expect_stop(1'b1);
		finish_move();
		wr(REG_CFG, 16'h0001);
		host.press(2);
		wait_move(9'h002);
		host.release_all();
		expect_stop(1'b1);
		finish_move();
		wr(REG_CFG, 16'h001D);
		host.press(1);
		wait_move(9'h001);
		host.release_all();
		finish_move();
		check("ls_complete", 16'h0002, {13'h0000, ls});
		rd_chk("status", REG_STATUS, 16'h0024);
		$display("test starts done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		{wr_s, rd_s, home_done, move_done} = 4'h0;
		addr = '0;
		wdata = '0;
		{cur_pos, pz_lo, pz_hi} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		t_regs();
		t_jog_teach();
		t_binary();
		t_zone();
		t_starts();
		wrap_up();
	end

	initial begin
		#(50 * 5000);
		n_errors++;
		wrap_up();
	end
endmodule // pio_cmd_tb_top

`default_nettype wire

/* File: test/pio_host_model.sv */
// Host controller model that drives the discrete command pins of the block.
`default_nettype none

module pio_host_model (
	input  wire logic                      clk_i,
	output logic      [pio_pkg::ST_W-1:0]  start_o,
	output logic      [pio_pkg::SEL_W-1:0] sel_o,
	output logic                           teach_o,
	output logic                           jog_fwd_o,
	output logic                           jog_rev_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import pio_pkg::*;

	initial begin
		start_o = '0;
		sel_o = '0;
		teach_o = 1'b0;
		jog_fwd_o = 1'b0;
		jog_rev_o = 1'b0;
	end

	// A pressed start pin stays high until release_all, which cuts a level move short.
	task automatic press(input int idx);
		@(posedge clk_i);
		start_o[idx] <= 1'b1;
	endtask

	task automatic release_all();
		@(posedge clk_i);
		start_o <= '0;
	endtask

	task automatic drive(input logic [SEL_W-1:0] sel, input logic tch, input logic f,
			input logic r);
		@(posedge clk_i);
		sel_o <= sel;
		teach_o <= tch;
		jog_fwd_o <= f;
		jog_rev_o <= r;
	endtask
endmodule // pio_host_model

`default_nettype wire
